/* File: hw/cds_pkg.sv */
package cds_pkg;
  // timebase
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MAMS_PER_MAH  = 3600 * MS_PER_S;
  // register indices
  localparam logic [3:0] REG_CMD     = 4'h0;
  localparam logic [3:0] REG_CTRL    = 4'h1;
  localparam logic [3:0] REG_TERMVAL = 4'h2;
  localparam logic [3:0] REG_CHG_MV  = 4'h3;
  localparam logic [3:0] REG_CHG_MA  = 4'h4;
  localparam logic [3:0] REG_LOAD_HI = 4'h5;
  localparam logic [3:0] REG_LOAD_LO = 4'h6;
  localparam logic [3:0] REG_POWER   = 4'h7;
  localparam logic [3:0] REG_PERIOD  = 4'h8;
  localparam logic [3:0] REG_DUTY    = 4'h9;
  localparam logic [3:0] REG_STATUS  = 4'hA;
  localparam logic [3:0] REG_SECONDS = 4'hB;
  localparam logic [3:0] REG_PASSED  = 4'hC;
  // control subcommands
  localparam logic [15:0] SUB_CONNECT    = 16'h0001;
  localparam logic [15:0] SUB_DISCONNECT = 16'h0002;
  localparam logic [15:0] SUB_RESET      = 16'h0003;
  // control register bit positions
  localparam int unsigned CTL_START    = 0;
  localparam int unsigned CTL_STOP     = 1;
  localparam int unsigned CTL_OP_LSB   = 2;
  localparam int unsigned CTL_SCRIPT   = 4;
  localparam int unsigned CTL_TERM_LSB = 5;
  // operation kinds
  typedef enum logic [1:0] {
    OP_CHARGE  = 2'h0,
    OP_CONST_I = 2'h1,
    OP_CONST_P = 2'h2,
    OP_PULSED  = 2'h3
  } cds_op_t;
  // sequencer states, gray along idle-charge-discharge
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_CHARGE = 2'h1,
    ST_DISCH  = 2'h3
  } cds_state_t;
  // termination selections
  localparam logic [2:0] TERM_LEVEL    = 3'h0;
  localparam logic [2:0] TERM_PERCENT  = 3'h1;
  localparam logic [2:0] TERM_CAPACITY = 3'h2;
  localparam logic [2:0] TERM_PASSED   = 3'h3;
  localparam logic [2:0] TERM_TIME     = 3'h4;
  localparam logic [2:0] TERM_FLAG_A   = 3'h5;
  localparam logic [2:0] TERM_FLAG_B   = 3'h6;
  // end causes
  localparam logic [1:0] END_NONE  = 2'h0;
  localparam logic [1:0] END_TERM  = 2'h1;
  localparam logic [1:0] END_STOP  = 2'h2;
  localparam logic [1:0] END_ABORT = 2'h3;
  // reset values
  localparam logic [15:0] CHG_MV_RST  = 16'h1068;
  localparam logic [15:0] CHG_MA_RST  = 16'h0200;
  localparam logic [15:0] LOAD_HI_RST = 16'h01F4;
  localparam logic [15:0] LOAD_LO_RST = 16'h0064;
  localparam logic [15:0] POWER_RST   = 16'h03E8;
  localparam logic [15:0] PERIOD_RST  = 16'h01F4;
  localparam logic [6:0]  DUTY_RST    = 7'h32;
  // legal ranges
  localparam logic [15:0] CHG_MA_MIN = 16'h0069;
  localparam logic [15:0] CHG_MA_MAX = 16'h07D0;
  localparam logic [15:0] CHG_MV_MIN = 16'h0DB0;
  localparam logic [15:0] CHG_MV_MAX = 16'h1130;
  localparam logic [15:0] LOAD_MIN   = 16'h0005;
  localparam logic [15:0] LOAD_MAX   = 16'h07D0;
  localparam logic [15:0] PERIOD_MIN = 16'h0032;
  localparam logic [15:0] PERIOD_MAX = 16'hAFC8;
  localparam logic [6:0]  DUTY_MIN   = 7'h0A;
  localparam logic [6:0]  DUTY_MAX   = 7'h5A;
  localparam logic [6:0]  PCT_FULL   = 7'h64;
endpackage

/* File: hw/cds_top.sv */
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cds_top
  import cds_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  // register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [15:0] rdata_out,
  // gauge readings
  input  wire logic        gauge_valid_in,
  input  wire logic [15:0] reported_mean_current_in,
  input  wire logic [15:0] reported_voltage_in,
  input  wire logic [15:0] reported_charge_percent_in,
  input  wire logic [15:0] reported_capacity_left_in,
  input  wire logic        full_charge_flag_in,
  input  wire logic        soc_threshold_one_flag_in,
  input  wire logic        soc_final_flag_in,
  // board controls
  output logic             battery_connected_out,
  output logic             charger_enable_out,
  output logic      [15:0] charge_voltage_out,
  output logic      [15:0] charge_current_out,
  output logic             load_enable_out,
  output logic      [15:0] load_current_out,
  output logic             power_mode_out,
  output logic      [15:0] load_power_out
);

  // refuse a millisecond divider that the counter cannot hold
  if (MS_CYCLES < 2 || MS_CYCLES > 65536) begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end

  typedef struct packed {
    cds_state_t  st;
    cds_op_t     op;
    logic        connected;
    logic        scripted;
    logic        refused;
    logic        ended;
    logic [1:0]  cause;
    logic [2:0]  term;
    logic [15:0] term_val;
    logic [15:0] chg_mv;
    logic [15:0] chg_ma;
    logic [15:0] load_hi;
    logic [15:0] load_lo;
    logic [15:0] power_mw;
    logic [15:0] period;
    logic [6:0]  duty;
    logic [15:0] phase;
    logic [15:0] div;
    logic        tick;
    logic [9:0]  ms_cnt;
    logic [15:0] seconds;
    logic [21:0] acc;
    logic [15:0] passed;
    logic        chg_en;
    logic        load_en;
    logic        pmode;
    logic [15:0] load_ma;
    logic [15:0] rdata;
  } cds_regs_t;

  cds_regs_t r;
  cds_regs_t next_r;

  // values after reset and after the reset subcommand
  function automatic cds_regs_t cds_defaults();
    cds_regs_t d;
    d          = '0;
    d.chg_mv   = CHG_MV_RST;
    d.chg_ma   = CHG_MA_RST;
    d.load_hi  = LOAD_HI_RST;
    d.load_lo  = LOAD_LO_RST;
    d.power_mw = POWER_RST;
    d.period   = PERIOD_RST;
    d.duty     = DUTY_RST;
    return d;
  endfunction

  logic        busy;
  logic        eval;
  logic        hit;
  logic        legal;
  logic        wr_ctrl;
  logic [1:0]  w_op;
  logic [2:0]  w_term;
  logic [15:0] mag;
  logic [21:0] sum;
  logic [22:0] hi_lim;
  logic [22:0] ph_pct;

  // next-state logic
  always_comb begin
    next_r     = r;
    next_r.tick = 1'b0;
    busy       = (r.st != ST_IDLE);
    eval       = gauge_valid_in | r.tick;
    wr_ctrl    = wr_en_in && (addr_in == REG_CTRL);
    w_op       = wdata_in[CTL_OP_LSB +: 2];
    w_term     = wdata_in[CTL_TERM_LSB +: 3];
    mag        = reported_mean_current_in[15] ? 16'(-reported_mean_current_in)
                                              : reported_mean_current_in;
    sum        = r.acc + 22'(mag);
    hi_lim     = 23'(r.period) * 23'(r.duty);
    ph_pct     = 23'(r.phase) * 23'(PCT_FULL);
    hit        = 1'b0;
    legal      = 1'b0;

    // millisecond timebase
    if (r.div == 16'(MS_CYCLES - 1)) begin
      next_r.div  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 16'h0001;
    end

    // elapsed time, pulse phase and passed charge while running
    if (busy && r.tick) begin
      if (r.ms_cnt == 10'(MS_PER_S - 1)) begin
        next_r.ms_cnt  = '0;
        next_r.seconds = r.seconds + 16'h0001;
      end else begin
        next_r.ms_cnt = r.ms_cnt + 10'h001;
      end
      if (r.phase >= r.period - 16'h0001) begin
        next_r.phase = '0;
      end else begin
        next_r.phase = r.phase + 16'h0001;
      end
      if (sum >= 22'(MAMS_PER_MAH)) begin
        next_r.acc    = sum - 22'(MAMS_PER_MAH);
        next_r.passed = r.passed + 16'h0001;
      end else begin
        next_r.acc = sum;
      end
    end

    // termination judgement
    case (r.st)
      ST_CHARGE: begin
        case (r.term)
          TERM_LEVEL:    hit = $signed(reported_mean_current_in) >= $signed(r.term_val);
          TERM_PERCENT:  hit = reported_charge_percent_in >= r.term_val;
          TERM_CAPACITY: hit = reported_capacity_left_in >= r.term_val;
          TERM_PASSED:   hit = r.passed >= r.term_val;
          TERM_TIME:     hit = r.seconds >= r.term_val;
          TERM_FLAG_A:   hit = full_charge_flag_in;
          default:       hit = 1'b1;
        endcase
      end
      ST_DISCH: begin
        case (r.term)
          TERM_LEVEL:    hit = reported_voltage_in <= r.term_val;
          TERM_PERCENT:  hit = reported_charge_percent_in <= r.term_val;
          TERM_CAPACITY: hit = reported_capacity_left_in <= r.term_val;
          TERM_PASSED:   hit = r.passed >= r.term_val;
          TERM_TIME:     hit = r.seconds >= r.term_val;
          TERM_FLAG_A:   hit = soc_threshold_one_flag_in;
          TERM_FLAG_B:   hit = soc_final_flag_in;
          default:       hit = 1'b1;
        endcase
      end
      default: hit = 1'b0;
    endcase
    if (busy && eval && hit) begin
      next_r.st    = ST_IDLE;
      next_r.ended = 1'b1;
      next_r.cause = END_TERM;
    end

    // setting writes, out-of-range values are dropped
    if (wr_en_in) begin
      if (addr_in == REG_TERMVAL) begin
        next_r.term_val = wdata_in;
      end else if (addr_in == REG_CHG_MV) begin
        if (wdata_in >= CHG_MV_MIN && wdata_in <= CHG_MV_MAX) next_r.chg_mv = wdata_in;
      end else if (addr_in == REG_CHG_MA) begin
        if (wdata_in >= CHG_MA_MIN && wdata_in <= CHG_MA_MAX) next_r.chg_ma = wdata_in;
      end else if (addr_in == REG_LOAD_HI) begin
        if (wdata_in >= LOAD_MIN && wdata_in <= LOAD_MAX) next_r.load_hi = wdata_in;
      end else if (addr_in == REG_LOAD_LO) begin
        if (wdata_in >= LOAD_MIN && wdata_in <= LOAD_MAX) next_r.load_lo = wdata_in;
      end else if (addr_in == REG_POWER) begin
        next_r.power_mw = wdata_in;
      end else if (addr_in == REG_PERIOD) begin
        if (wdata_in >= PERIOD_MIN && wdata_in <= PERIOD_MAX) next_r.period = wdata_in;
      end else if (addr_in == REG_DUTY) begin
        if (wdata_in[15:7] == '0 && wdata_in[6:0] >= DUTY_MIN && wdata_in[6:0] <= DUTY_MAX) begin
          next_r.duty = wdata_in[6:0];
        end
      end
    end

    // start and stop, manual or scripted
    legal = (w_term <= ((w_op == OP_CHARGE) ? TERM_FLAG_A : TERM_FLAG_B)) &&
            (wdata_in[CTL_SCRIPT] || !((w_term == TERM_PASSED) || (w_term == TERM_FLAG_B) ||
             ((w_op != OP_CHARGE) && (w_term == TERM_FLAG_A))));
    if (wr_ctrl && wdata_in[CTL_STOP] && busy) begin
      next_r.st    = ST_IDLE;
      next_r.ended = 1'b1;
      next_r.cause = END_STOP;
    end else if (wr_ctrl && wdata_in[CTL_START]) begin
      if (r.connected && !busy && legal) begin
        next_r.st       = (w_op == OP_CHARGE) ? ST_CHARGE : ST_DISCH;
        next_r.op       = cds_op_t'(w_op);
        next_r.scripted = wdata_in[CTL_SCRIPT];
        next_r.term     = w_term;
        next_r.refused  = 1'b0;
        next_r.ended    = 1'b0;
        next_r.cause    = END_NONE;
        next_r.seconds  = '0;
        next_r.ms_cnt   = '0;
        next_r.phase    = '0;
        next_r.acc      = '0;
        next_r.passed   = '0;
      end else begin
        next_r.refused = 1'b1;
      end
    end

    // control subcommands
    if (wr_en_in && addr_in == REG_CMD) begin
      if (wdata_in == SUB_CONNECT) begin
        next_r.connected = 1'b1;
      end else if (wdata_in == SUB_DISCONNECT) begin
        next_r.connected = 1'b0;
        if (busy) begin
          next_r.st    = ST_IDLE;
          next_r.ended = 1'b1;
          next_r.cause = END_ABORT;
        end
      end else if (wdata_in == SUB_RESET) begin
        next_r = cds_defaults();
      end
    end

    // board drive, all off when idle
    next_r.chg_en  = (next_r.st == ST_CHARGE);
    next_r.load_en = (next_r.st == ST_DISCH);
    next_r.pmode   = next_r.load_en && (next_r.op == OP_CONST_P);
    ph_pct         = 23'(next_r.phase) * 23'(PCT_FULL);
    hi_lim         = 23'(next_r.period) * 23'(next_r.duty);
    if (!next_r.load_en || next_r.op == OP_CONST_P) begin
      next_r.load_ma = '0;
    end else if (next_r.op == OP_PULSED) begin
      next_r.load_ma = (ph_pct < hi_lim) ? next_r.load_hi : next_r.load_lo;
    end else begin
      next_r.load_ma = next_r.load_hi;
    end

    // read data, present only in the cycle after the strobe
    next_r.rdata = '0;
    if (rd_en_in) begin
      if (addr_in == REG_CTRL) begin
        next_r.rdata = 16'({r.term, r.scripted, r.op, 2'h0});
      end else if (addr_in == REG_TERMVAL) begin
        next_r.rdata = r.term_val;
      end else if (addr_in == REG_CHG_MV) begin
        next_r.rdata = r.chg_mv;
      end else if (addr_in == REG_CHG_MA) begin
        next_r.rdata = r.chg_ma;
      end else if (addr_in == REG_LOAD_HI) begin
        next_r.rdata = r.load_hi;
      end else if (addr_in == REG_LOAD_LO) begin
        next_r.rdata = r.load_lo;
      end else if (addr_in == REG_POWER) begin
        next_r.rdata = r.power_mw;
      end else if (addr_in == REG_PERIOD) begin
        next_r.rdata = r.period;
      end else if (addr_in == REG_DUTY) begin
        next_r.rdata = 16'(r.duty);
      end else if (addr_in == REG_STATUS) begin
        next_r.rdata = 16'({r.op, r.cause, r.ended, r.refused, busy, r.connected});
      end else if (addr_in == REG_SECONDS) begin
        next_r.rdata = r.seconds;
      end else if (addr_in == REG_PASSED) begin
        next_r.rdata = r.passed;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      r <= cds_defaults();
    end else begin
      r <= next_r;
    end
  end

  // outputs from flops
  assign rdata_out             = r.rdata;
  assign battery_connected_out = r.connected;
  assign charger_enable_out    = r.chg_en;
  assign charge_voltage_out    = r.chg_mv;
  assign charge_current_out    = r.chg_ma;
  assign load_enable_out       = r.load_en;
  assign load_current_out      = r.load_ma;
  assign power_mode_out        = r.pmode;
  assign load_power_out        = r.power_mw;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_cmd(logic [15:0] code);
    wr_en_in && (addr_in == REG_CMD) && (wdata_in == code);
  endsequence
  sequence s_start_req;
    wr_en_in && (addr_in == REG_CTRL) && wdata_in[CTL_START] && !wdata_in[CTL_STOP];
  endsequence

  a_conn_lamp_on: assert property (s_cmd(SUB_CONNECT) |=> battery_connected_out)
    else $error("connect did not light indicator");
  a_gate_on_conn: assert property (s_start_req ##0 !r.connected |=>
    !busy ##1 !charger_enable_out && !load_enable_out)
    else $error("operation started while not connected");
  a_disc_stops: assert property (s_cmd(SUB_DISCONNECT) |=>
    !battery_connected_out && !charger_enable_out && !load_enable_out)
    else $error("disconnect left battery active");
  a_chg_range: assert property (
    charge_current_out >= CHG_MA_MIN && charge_current_out <= CHG_MA_MAX &&
    charge_voltage_out >= CHG_MV_MIN && charge_voltage_out <= CHG_MV_MAX)
    else $error("charge setting out of range");
  a_load_range: assert property (load_enable_out && !power_mode_out |->
    load_current_out >= LOAD_MIN && load_current_out <= LOAD_MAX)
    else $error("load current out of range");
  a_single_op: assert property (!(charger_enable_out && load_enable_out))
    else $error("charger and load both on");
  a_idle_off: assert property (!busy |-> !charger_enable_out && !load_enable_out &&
    load_current_out == 16'h0000 && !power_mode_out)
    else $error("board drive active while idle");
  a_taper_end: assert property (r.st == ST_CHARGE && r.term == TERM_LEVEL &&
    gauge_valid_in && $signed(reported_mean_current_in) >= $signed(r.term_val)
    |=> !charger_enable_out)
    else $error("taper termination missed");
  a_time_end: assert property (r.st == ST_CHARGE && r.term == TERM_TIME && r.tick &&
    r.seconds >= r.term_val |=> !charger_enable_out)
    else $error("time termination missed");
  a_floor_end: assert property (r.st == ST_DISCH && r.term == TERM_LEVEL &&
    gauge_valid_in && reported_voltage_in <= r.term_val |=> !load_enable_out)
    else $error("voltage floor termination missed");
  a_pulse_levels: assert property (load_enable_out && r.op == OP_PULSED |->
    load_current_out == r.load_hi || load_current_out == r.load_lo)
    else $error("pulsed load not at high or low");

endmodule
`default_nettype wire

/* File: sim/cds_gauge_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stand-in for the attached gauge: readings only change with a fresh-reading pulse
module cds_gauge_model (
  // clock, reset and pace
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        slow_in,
  // readings the bench wants published
  input  wire logic [15:0] cur_in,
  input  wire logic [15:0] volt_in,
  input  wire logic [15:0] pct_in,
  input  wire logic [15:0] cap_in,
  input  wire logic [2:0]  flags_in,
  // readings seen by the sequencer
  output logic             valid_out,
  output logic      [15:0] cur_out,
  output logic      [15:0] volt_out,
  output logic      [15:0] pct_out,
  output logic      [15:0] cap_out,
  output logic      [2:0]  flags_out
);
  logic [5:0] cnt;

  // poll every 3 cycles, or every 37 when slow, like a gauge read over a serial link
  always_ff @(posedge core_clk_in) begin
    valid_out <= 1'b0;
    if (srst_in) begin
      cnt <= 6'h00;
      {cur_out, volt_out, pct_out, cap_out, flags_out} <= '0;
    end else if (cnt >= (slow_in ? 6'h24 : 6'h02)) begin
      cnt <= 6'h00;
      valid_out <= 1'b1;
      {cur_out, volt_out, pct_out, cap_out, flags_out} <=
        {cur_in, volt_in, pct_in, cap_in, flags_in};
    end else begin
      cnt <= cnt + 6'h01;
    end
  end
endmodule
`default_nettype wire

/* File: sim/cds_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cds_top_tb_top
  import cds_pkg::*;
;
  logic             core_clk, srst, wr_en, rd_en, slow, rd_d, m_valid;
  logic             conn, chg_en, load_en, pmode;
  logic      [3:0]  addr;
  logic      [2:0]  g_flg, m_flg;
  logic      [15:0] wdata, rdata, g_cur, g_volt, g_pct, g_cap, m_cur, m_volt, m_pct, m_cap;
  logic      [15:0] chg_mv, chg_ma, load_i, load_p, hi, v;
  logic      [15:0] exp_q[$];
  logic      [31:0] rs;
  int               fails, n_tests, i, k;
  // range probes and their expected outcome (refused writes keep the old value)
  localparam logic [15:0] MA_V[4] = '{16'h0068, 16'h0069, 16'h07D1, 16'h07D0};
  localparam logic [15:0] MA_E[4] = '{16'h0200, 16'h0069, 16'h0069, 16'h07D0};
  localparam logic [15:0] MV_V[4] = '{16'h0DAF, 16'h0DB0, 16'h1131, 16'h1130};
  localparam logic [15:0] MV_E[4] = '{16'h1068, 16'h0DB0, 16'h0DB0, 16'h1130};
  localparam logic [2:0]  REF_T[5] = '{3'h3, 3'h6, 3'h3, 3'h5, 3'h6};
  // operation runs: kind, end condition, scripted, end value
  localparam logic [1:0]  RUN_O[13] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
                                         2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h1};
  localparam logic [2:0]  RUN_T[13] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h5,
                                         3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6};
  localparam logic        RUN_S[13] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1,
                                         1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
  localparam logic [15:0] RUN_V[13] = '{16'h0032, 16'h003C, 16'h03E8, 16'h0001, 16'h0001,
                                         16'h0000, 16'h0BB8, 16'h0014, 16'h01F4, 16'h0001,
                                         16'h0001, 16'h0000, 16'h0000};

  cds_top #(.MS_CYCLES(4)) dut (
    .core_clk_in(core_clk), .srst_in(srst), .addr_in(addr), .wdata_in(wdata),
    .wr_en_in(wr_en), .rd_en_in(rd_en), .rdata_out(rdata), .gauge_valid_in(m_valid),
    .reported_mean_current_in(m_cur), .reported_voltage_in(m_volt),
    .reported_charge_percent_in(m_pct), .reported_capacity_left_in(m_cap),
    .full_charge_flag_in(m_flg[0]), .soc_threshold_one_flag_in(m_flg[1]),
    .soc_final_flag_in(m_flg[2]), .battery_connected_out(conn), .charger_enable_out(chg_en),
    .charge_voltage_out(chg_mv), .charge_current_out(chg_ma), .load_enable_out(load_en),
    .load_current_out(load_i), .power_mode_out(pmode), .load_power_out(load_p));

  cds_gauge_model gauge (
    .core_clk_in(core_clk), .srst_in(srst), .slow_in(slow), .cur_in(g_cur),
    .volt_in(g_volt), .pct_in(g_pct), .cap_in(g_cap), .flags_in(g_flg),
    .valid_out(m_valid), .cur_out(m_cur), .volt_out(m_volt), .pct_out(m_pct),
    .cap_out(m_cap), .flags_out(m_flg));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [15:0] ctl(input logic [1:0] op, input logic s, input logic [2:0] t,
                                      input logic go, input logic halt);
    return {8'h00, t, s, op, halt, go};
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  // the expected answer is queued before the strobe goes out
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
  endtask

  // gauge readings just short of, or exactly at, the end value of condition t
  task automatic set_g(input logic [1:0] op, input logic [2:0] t, input logic [15:0] e,
                       input logic hit);
    logic [15:0] cu, vo, pe, ca;
    logic [2:0]  fl;
    logic        c;
    c = (op == 2'h0);
    cu = c ? 16'hF830 : 16'h07D0;
    vo = 16'h0FA0;
    pe = c ? 16'h0000 : 16'h0064;
    ca = c ? 16'h0000 : 16'h1388;
    fl = 3'h0;
    case (t)
      TERM_LEVEL: if (c) cu = hit ? e : e - 16'h0001; else vo = hit ? e : e + 16'h0001;
      TERM_PERCENT: pe = hit ? e : (c ? e - 16'h0001 : e + 16'h0001);
      TERM_CAPACITY: ca = hit ? e : (c ? e - 16'h0001 : e + 16'h0001);
      TERM_FLAG_A: fl = c ? {2'b00, hit} : {1'b0, hit, 1'b0};
      TERM_FLAG_B: fl = {hit, 2'b00};
      default: ;
    endcase
    @(posedge core_clk);
    {g_cur, g_volt, g_pct, g_cap, g_flg} <= {cu, vo, pe, ca, fl};
  endtask

  // one full operation from start to its own end condition
  task automatic run_op(input logic [1:0] op, input logic [2:0] t, input logic s,
                        input logic [15:0] e);
    int   n;
    logic lvl;
    lvl = (t != TERM_PASSED) && (t != TERM_TIME);
    set_g(op, t, e, 1'b0);
    slow <= ~slow;
    tick(40);
    wr(REG_TERMVAL, e);
    wr(REG_CTRL, ctl(op, s, t, 1'b1, 1'b0));
    tick(2);
    chk("chg_en", chg_en, op == 2'h0);
    chk("load_en", load_en, op != 2'h0);
    chk("pmode", pmode, op == 2'h2);
    if (op != 2'h3) chk("load_i", load_i, (op == 2'h1) ? hi : 16'h0000);
    n = 2;
    if (lvl) begin
      tick(60);
      chk("still_on", chg_en | load_en, 1'b1);
      set_g(op, t, e, 1'b1);
      n = 0;
    end
    while ((chg_en | load_en) && n < 9000) begin
      tick(1);
      n++;
    end
    if (lvl) chk("end_lat", n <= 45, 1'b1);
    else if (t == TERM_TIME) chk("secs", n > 3988 && n < 4012, 1'b1);
    else chk("passed", n > 7180 && n < 7216, 1'b1);
    rd(REG_STATUS, {8'h00, op, 6'h19});
    rd(REG_CTRL, {8'h00, t, s, op, 2'h0});
    if (t == TERM_TIME) rd(REG_SECONDS, 16'h0001);
    else if (t == TERM_PASSED) rd(REG_PASSED, 16'h0001);
  endtask

  // answers are compared in the one cycle that they stand
  always @(posedge core_clk) begin
    if (rd_d) chk("rdata", rdata, exp_q.pop_front());
    rd_d <= rd_en;
  end

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // hang guard, well above the roughly 24000 cycles the run needs
  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

  initial begin
    {addr, wdata, wr_en, rd_en, slow} = '0;
    srst = 1'b1;
    {g_cur, g_volt, g_pct, g_cap, g_flg} = '0;
    fails = 0;
    n_tests = 0;
    rs = 32'h1067;
    hi = LOAD_HI_RST;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    tick(1);
    // defaults, unmapped read and a start before connect
    chk("mv", chg_mv, CHG_MV_RST);
    chk("ma", chg_ma, CHG_MA_RST);
    chk("pw", load_p, POWER_RST);
    chk("outs", {conn, chg_en, load_en, pmode}, 4'h0);
    rd(REG_STATUS, 16'h0000);
    rd(4'hD, 16'h0000);
    wr(REG_CTRL, ctl(2'h0, 1'b0, TERM_TIME, 1'b1, 1'b0));
    tick(2);
    chk("chg_en", chg_en, 1'b0);
    rd(REG_STATUS, 16'h0004);
    // setting ranges at both edges
    for (i = 0; i < 4; i++) begin
      wr(REG_CHG_MA, MA_V[i]);
      wr(REG_CHG_MV, MV_V[i]);
      tick(1);
      chk("ma", chg_ma, MA_E[i]);
      chk("mv", chg_mv, MV_E[i]);
    end
    rs = xs(rs);
    v = 16'h0DB0 + 16'(rs % 897);
    wr(REG_CHG_MV, v);
    tick(1);
    chk("mv", chg_mv, v);
    wr(REG_POWER, rs[31:16]);
    tick(1);
    chk("pw", load_p, rs[31:16]);
    rs = xs(rs);
    hi = 16'h0005 + 16'(rs % 1996);
    wr(REG_LOAD_HI, hi);
    wr(REG_LOAD_HI, 16'h0004);
    wr(REG_LOAD_HI, 16'h07D1);
    wr(REG_CMD, SUB_CONNECT);
    tick(1);
    chk("conn", conn, 1'b1);
    rd(REG_STATUS, 16'h0005);
    // second start while busy, then stop
    set_g(2'h0, TERM_LEVEL, 16'h0032, 1'b0);
    wr(REG_TERMVAL, 16'h0032);
    wr(REG_CTRL, ctl(2'h0, 1'b0, TERM_LEVEL, 1'b1, 1'b0));
    wr(REG_CTRL, ctl(2'h1, 1'b0, TERM_TIME, 1'b1, 1'b0));
    tick(2);
    chk("one_op", {chg_en, load_en}, 2'b10);
    rd(REG_STATUS, 16'h0007);
    wr(REG_CTRL, ctl(2'h0, 1'b0, TERM_LEVEL, 1'b0, 1'b1));
    tick(3);
    chk("stopped", chg_en, 1'b0);
    rd(REG_STATUS, 16'h002D);
    // end conditions that need scripted control, or the other direction
    for (i = 0; i < 5; i++) begin
      wr(REG_CTRL, ctl((i < 2) ? 2'h0 : 2'h1, 1'b0, REF_T[i], 1'b1, 1'b0));
      tick(3);
      chk("refused", {chg_en, load_en}, 2'b00);
    end
    for (i = 0; i < 13; i++) run_op(RUN_O[i], RUN_T[i], RUN_S[i], RUN_V[i]);
    // pulsed load at the shortest period and lowest duty
    wr(REG_PERIOD, 16'h0031);
    wr(REG_PERIOD, 16'h0032);
    wr(REG_DUTY, 16'h0009);
    wr(REG_DUTY, 16'h000A);
    wr(REG_LOAD_LO, 16'h07D1);
    wr(REG_TERMVAL, 16'h0001);
    wr(REG_CTRL, ctl(2'h3, 1'b0, TERM_TIME, 1'b1, 1'b0));
    tick(8);
    k = 0;
    for (i = 0; i < 200; i++) begin
      if (load_i === hi) k++;
      else if (load_i !== LOAD_LO_RST) k += 1000;
      tick(1);
    end
    chk("pulse_hi", 16'(k), 16'h0014);
    wr(REG_CTRL, ctl(2'h3, 1'b0, TERM_TIME, 1'b0, 1'b1));
    tick(3);
    rd(REG_STATUS, 16'h00E9);
    // disconnect aborts, then the reset subcommand restores defaults
    wr(REG_CTRL, ctl(2'h1, 1'b0, TERM_TIME, 1'b1, 1'b0));
    wr(REG_CMD, SUB_DISCONNECT);
    tick(3);
    chk("abort", {conn, load_en}, 2'b00);
    rd(REG_STATUS, 16'h0078);
    wr(REG_CTRL, ctl(2'h1, 1'b0, TERM_TIME, 1'b1, 1'b0));
    tick(2);
    chk("no_conn", load_en, 1'b0);
    wr(REG_CMD, SUB_CONNECT);
    wr(REG_CHG_MA, 16'h07D0);
    wr(REG_CMD, SUB_RESET);
    tick(1);
    chk("rst_ma", chg_ma, CHG_MA_RST);
    chk("rst_conn", conn, 1'b0);
    rd(REG_STATUS, 16'h0000);
    tick(4);
    end_of_test();
  end
endmodule
`default_nettype wire
